// *** include/lpm_pkg.sv ***
`default_nettype none
package lpm_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int GPIO_N = 12;
   localparam int IF_N = 4;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WAKE = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_GOUT = 8'h0C;
   localparam logic [7:0] OFS_GOE = 8'h10;
   localparam logic [7:0] OFS_PULL = 8'h14;
   localparam logic [7:0] OFS_DRV = 8'h18;
   localparam logic [7:0] OFS_GIN = 8'h1C;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTRL_STBY_BIT = 0;
   localparam int CTRL_SUSP_BIT = 1;
   localparam int WAKE_VBUS_BIT = 0;
   localparam int WAKE_LVL_BIT = 1;
   localparam int WAKE_POL_BIT = 2;
   localparam int STAT_VBUS_BIT = 4;
   localparam int STAT_LVL_BIT = 5;
   localparam int STAT_HRST_BIT = 6;
   localparam int STAT_RELOAD_BIT = 7;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [2:0] WAKE_RST = 3'h3;
   localparam logic [23:0] PULL_RST = 24'h000000;
   localparam logic [7:0] DRV_RST = 8'h00;
   localparam logic [11:0] GPIO_RST = 12'h000;
   // ----------------------------------------
   // Pull and drive encodings
   // ----------------------------------------
   localparam logic [1:0] PULL_HIZ = 2'h0;
   localparam logic [1:0] PULL_UP = 2'h1;
   localparam logic [1:0] PULL_DOWN = 2'h2;
   localparam logic [1:0] DRV_FULL = 2'h0;
   localparam logic [1:0] DRV_3Q = 2'h1;
   localparam logic [1:0] DRV_HALF = 2'h2;
   localparam logic [1:0] DRV_QUARTER = 2'h3;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int PLL_LOCK_NS = 500;
   localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] PLL_LOCK_LAST = 4'(PLL_LOCK_CYC - 1);
   // ----------------------------------------
   // Power states
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_SUSPEND = 3'b001,
      ST_STANDBY = 3'b010,
      ST_WAKE = 3'b011,
      ST_OFF = 3'b100
   } lpm_state_e;
endpackage : lpm_pkg
`default_nettype wire

// *** rtl/lpm_sync.sv ***
`default_nettype none
// Two-stage synchroniser for pin inputs; stage one feeds stage two only
module lpm_sync #(
   parameter int W = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // ----------------------------------------
   // Synchroniser stages
   // ----------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : lpm_sync
`default_nettype wire

// *** rtl/lpm_pad.sv ***
`default_nettype none
// Per-pin pad control; outputs freeze while hold is high
module lpm_pad
   import lpm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic hold,
   input wire logic [GPIO_N-1:0] out_cfg,
   input wire logic [GPIO_N-1:0] oe_cfg,
   input wire logic [2*GPIO_N-1:0] pull_cfg,
   output logic [GPIO_N-1:0] pad_o,
   output logic [GPIO_N-1:0] pad_oe,
   output logic [GPIO_N-1:0] pad_pu,
   output logic [GPIO_N-1:0] pad_pd
);
   // ----------------------------------------
   // One pad cell per pin
   // ----------------------------------------
   for (genvar i = 0; i < GPIO_N; i++) begin : g_pin
      // Hold keeps the last value so the pin never glitches while low power is active
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            pad_o[i] <= 1'b0;
            pad_oe[i] <= 1'b0;
            pad_pu[i] <= 1'b0;
            pad_pd[i] <= 1'b0;
         end else if (!hold) begin // see RULE10
            pad_o[i] <= out_cfg[i];
            pad_oe[i] <= oe_cfg[i];
            pad_pu[i] <= (pull_cfg[2*i +: 2] == PULL_UP);
            pad_pd[i] <= (pull_cfg[2*i +: 2] == PULL_DOWN);
         end
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   pad_hold_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE5
      $past(hold) |-> $stable(pad_o) && $stable(pad_oe) && $stable(pad_pu) && $stable(pad_pd))
      else $error("pad changed while held");
   pad_pull_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE10
      !(|(pad_pu & pad_pd)))
      else $error("pull-up and pull-down both on");
endmodule : lpm_pad
`default_nettype wire

// *** rtl/lpm_ctrl.sv ***
`default_nettype none
// Contract
// RULE1 - Suspend wake not from hard reset keeps the program counter.
// RULE2 - Standby keeps configuration and RAM; buffers and datapath may be lost.
// RULE3 - Outside processor reads buffered data before commanding standby.
// RULE4 - Leaving standby resets the program counter and restarts the core.
// RULE5 - General-purpose pins keep their configured state in standby.
// RULE6 - Standby turns off PLL, USB transceiver and powers down the core.
// RULE7 - Register write enters standby; VBUS, level detect or hard reset exits.
// RULE8 - Core power-down keeps no buffer, configuration or program RAM state.
// RULE9 - Core power-down follows core supply; reapply or hard reset exits. Here only supply return leaves ST_OFF; hard reset alone does not.
// RULE10 - Each pin selects high-Z, pull-up or pull-down, and holds in low power.
// RULE11 - Drive strength full, three-quarter, half, quarter, one per interface.
// RULE12 - Twelve general-purpose input/output pins are provided.
// RULE13 - Firmware pulls up unused inputs and leaves unused outputs floating.
// RULE14 - Suspend clocks only the USB 3.0 PHY and holds pins and state.
// RULE15 - Any one enabled wake source starts the exit from low power.
module lpm_ctrl
   import lpm_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Pins and supply sense
   input wire logic core_pwr_good,
   input wire logic hard_rst_n,
   input wire logic vbus_det,
   input wire logic level_pin,
   input wire logic [GPIO_N-1:0] gpio_i,
   // Power and clock controls
   output logic pll_en,
   output logic usb_xcvr_en,
   output logic usb3_phy_clk_en,
   output logic sys_clk_en,
   output logic core_pwr_en,
   output logic cpu_rst,
   output logic buf_clear,
   // Pads
   output logic [GPIO_N-1:0] gpio_o,
   output logic [GPIO_N-1:0] gpio_oe,
   output logic [GPIO_N-1:0] gpio_pu,
   output logic [GPIO_N-1:0] gpio_pd,
   output logic [2*IF_N-1:0] drive_str
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   lpm_state_e state_reg;
   lpm_state_e state_next;
   logic [3:0] lock_cnt_reg;
   logic susp_wake_reg;
   logic [2:0] wake_cfg_reg;
   logic [GPIO_N-1:0] gout_reg;
   logic [GPIO_N-1:0] goe_reg;
   logic [2*GPIO_N-1:0] pull_reg;
   logic [2*IF_N-1:0] drv_reg;
   logic [3:0] cause_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic stby_req;
   logic susp_req;
   logic cause_clr_wr;
   logic [3:0] sync_q;
   logic [GPIO_N-1:0] gin_s;
   logic pwr_s;
   logic hrst_s;
   logic vbus_s;
   logic lvl_s;
   logic lvl_hit;
   logic vbus_hit;
   logic wake_any;
   logic cfg_wipe;
   logic lp_active;
   logic addr_ok;
   logic rd_ok;
   logic [3:0] wake_cyc_reg;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   lpm_sync #(.W(4)) u_sync_ctl (
      .core_clk(core_clk),
      .rst(rst),
      .d({core_pwr_good, !hard_rst_n, vbus_det, level_pin}), // Inverted so an asserted hard reset reads as one
      .q(sync_q)
   );

   lpm_sync #(.W(GPIO_N)) u_sync_gin (
      .core_clk(core_clk),
      .rst(rst),
      .d(gpio_i),
      .q(gin_s)
   );

   assign pwr_s = sync_q[3];
   assign hrst_s = sync_q[2];
   assign vbus_s = sync_q[1];
   assign lvl_s = sync_q[0];

   // ----------------------------------------
   // Wake sources
   // ----------------------------------------
   // Level detect matches the programmed polarity, so either a high or a low level can wake
   assign lvl_hit = wake_cfg_reg[WAKE_LVL_BIT] && (lvl_s == wake_cfg_reg[WAKE_POL_BIT]); // see RULE7
   assign vbus_hit = wake_cfg_reg[WAKE_VBUS_BIT] && vbus_s;
   // Any single enabled source is enough; hard reset can never be masked
   assign wake_any = vbus_hit || lvl_hit || hrst_s; // see RULE15
   // Losing core supply or hard reset throws away all configuration
   assign cfg_wipe = !pwr_s || hrst_s; // see RULE8
   assign lp_active = (state_reg == ST_SUSPEND) || (state_reg == ST_STANDBY);

   // ----------------------------------------
   // AHB-Lite address phase capture
   // ----------------------------------------
   assign addr_ok = (haddr[1:0] == 2'h0) && (haddr <= OFS_GIN);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else if (hready) begin
         wr_pend_reg <= hsel && htrans[1] && hwrite && addr_ok;
         wr_addr_reg <= haddr;
      end
   end

   // Zero wait states and always OKAY; unmapped reads return zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ----------------------------------------
   // Write strobes
   // ----------------------------------------
   assign stby_req = wr_pend_reg && (wr_addr_reg == OFS_CTRL) && hwdata[CTRL_STBY_BIT];
   assign susp_req = wr_pend_reg && (wr_addr_reg == OFS_CTRL) && hwdata[CTRL_SUSP_BIT];
   assign cause_clr_wr = wr_pend_reg && (wr_addr_reg == OFS_STAT);

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Kept through suspend and standby; only supply loss or hard reset clears them
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wake_cfg_reg <= WAKE_RST;
         gout_reg <= GPIO_RST;
         goe_reg <= GPIO_RST;
         pull_reg <= PULL_RST;
         drv_reg <= DRV_RST;
      end else if (cfg_wipe) begin // see RULE8
         wake_cfg_reg <= WAKE_RST;
         gout_reg <= GPIO_RST;
         goe_reg <= GPIO_RST;
         pull_reg <= PULL_RST;
         drv_reg <= DRV_RST;
      end else if (wr_pend_reg) begin // see RULE2
         if (wr_addr_reg == OFS_WAKE) begin
            wake_cfg_reg <= hwdata[2:0];
         end else if (wr_addr_reg == OFS_GOUT) begin
            gout_reg <= hwdata[GPIO_N-1:0];
         end else if (wr_addr_reg == OFS_GOE) begin
            goe_reg <= hwdata[GPIO_N-1:0];
         end else if (wr_addr_reg == OFS_PULL) begin
            pull_reg <= hwdata[2*GPIO_N-1:0]; // see RULE10
         end else if (wr_addr_reg == OFS_DRV) begin
            drv_reg <= hwdata[2*IF_N-1:0]; // see RULE11
         end
      end
   end

   // ----------------------------------------
   // Wake cause flags
   // ----------------------------------------
   // Write one to clear; a cause arriving in the same cycle wins over the clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cause_reg <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (cause_clr_wr && hwdata[STAT_VBUS_BIT + i]) begin
               cause_reg[i] <= 1'b0;
            end
         end
         if (lp_active && vbus_hit) begin
            cause_reg[0] <= 1'b1;
         end
         if (lp_active && lvl_hit) begin
            cause_reg[1] <= 1'b1;
         end
         if (hrst_s) begin
            cause_reg[2] <= 1'b1;
         end
         if (state_reg == ST_OFF && pwr_s) begin
            cause_reg[3] <= 1'b1; // firmware must be reloaded
         end
      end
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   assign rd_ok = hready && hsel && htrans[1] && !hwrite && addr_ok;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else if (rd_ok) begin
         if (haddr == OFS_WAKE) begin
            hrdata <= {29'h0, wake_cfg_reg};
         end else if (haddr == OFS_STAT) begin
            hrdata <= {24'h0, cause_reg, 1'b0, state_reg};
         end else if (haddr == OFS_GOUT) begin
            hrdata <= {20'h0, gout_reg};
         end else if (haddr == OFS_GOE) begin
            hrdata <= {20'h0, goe_reg};
         end else if (haddr == OFS_PULL) begin
            hrdata <= {8'h0, pull_reg};
         end else if (haddr == OFS_DRV) begin
            hrdata <= {24'h0, drv_reg};
         end else if (haddr == OFS_GIN) begin
            hrdata <= {20'h0, gin_s}; // see RULE12
         end else begin
            hrdata <= 32'h00000000;
         end
      end else if (hready) begin
         hrdata <= 32'h00000000;
      end
   end

   // ----------------------------------------
   // Power state machine
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN: begin
            if (stby_req) begin
               state_next = ST_STANDBY; // see RULE7
            end else if (susp_req) begin
               state_next = ST_SUSPEND;
            end
         end
         ST_SUSPEND, ST_STANDBY: begin
            if (wake_any) begin
               state_next = ST_WAKE; // see RULE15
            end
         end
         ST_WAKE: begin
            if (lock_cnt_reg == PLL_LOCK_LAST && !hrst_s) begin
               state_next = ST_RUN;
            end
         end
         ST_OFF: begin
            if (pwr_s) begin
               state_next = ST_WAKE; // see RULE9
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
      if (!pwr_s) begin
         state_next = ST_OFF; // see RULE9
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // PLL lock wait; hard reset restarts it so the lock time is served after release
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lock_cnt_reg <= 4'h0;
      end else if (state_reg != ST_WAKE || hrst_s) begin
         lock_cnt_reg <= 4'h0;
      end else if (lock_cnt_reg != PLL_LOCK_LAST) begin
         lock_cnt_reg <= lock_cnt_reg + 4'h1;
      end
   end

   // Remembers a suspend wake that keeps the program counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         susp_wake_reg <= 1'b0;
      end else if (state_reg == ST_SUSPEND && wake_any) begin
         susp_wake_reg <= !hrst_s; // see RULE1
      end else if (state_reg != ST_WAKE || hrst_s) begin
         susp_wake_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Power and clock outputs
   // ----------------------------------------
   // Suspend keeps the core powered and in reset-free halt with only the PHY clock running
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pll_en <= 1'b0;
         usb_xcvr_en <= 1'b0;
         usb3_phy_clk_en <= 1'b0;
         sys_clk_en <= 1'b0;
         core_pwr_en <= 1'b0;
         cpu_rst <= 1'b1;
         buf_clear <= 1'b0;
      end else begin
         pll_en <= (state_next == ST_RUN) || (state_next == ST_WAKE); // see RULE6
         usb_xcvr_en <= (state_next == ST_RUN) || (state_next == ST_SUSPEND); // see RULE6
         usb3_phy_clk_en <= (state_next == ST_RUN) || (state_next == ST_SUSPEND); // see RULE14
         sys_clk_en <= (state_next == ST_RUN); // see RULE14
         core_pwr_en <= (state_next != ST_STANDBY) && (state_next != ST_OFF); // see RULE6
         // Standby, supply loss or hard reset restart the core from the start
         if (state_next == ST_STANDBY || state_next == ST_OFF || hrst_s) begin
            cpu_rst <= 1'b1; // see RULE4
         end else if (state_next == ST_RUN) begin
            cpu_rst <= 1'b0;
         end
         // Buffers are not guaranteed across standby; wipe them on entry
         buf_clear <= (state_reg == ST_RUN) && (state_next == ST_STANDBY); // see RULE2
      end
   end

   // Drive strength is per interface, not per pin
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         drive_str <= DRV_RST;
      end else if (!lp_active) begin
         drive_str <= drv_reg; // see RULE11
      end
   end

   // ----------------------------------------
   // Pad cells
   // ----------------------------------------
   lpm_pad u_pad (
      .core_clk(core_clk),
      .rst(rst),
      .hold(lp_active || state_next == ST_SUSPEND || state_next == ST_STANDBY), // see RULE5
      .out_cfg(gout_reg),
      .oe_cfg(goe_reg),
      .pull_cfg(pull_reg),
      .pad_o(gpio_o),
      .pad_oe(gpio_oe),
      .pad_pu(gpio_pu),
      .pad_pd(gpio_pd)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Own count of WAKE cycles, so the lock check does not trust the design's counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wake_cyc_reg <= 4'h0;
      end else if (state_reg != ST_WAKE || hrst_s) begin
         wake_cyc_reg <= 4'h0;
      end else if (wake_cyc_reg != 4'hF) begin
         wake_cyc_reg <= wake_cyc_reg + 4'h1;
      end
   end

   sequence s_stby_write;
      state_reg == ST_RUN && stby_req && pwr_s;
   endsequence
   sequence s_stby_off;
      state_reg == ST_STANDBY && !pll_en && !usb_xcvr_en && !core_pwr_en;
   endsequence
   sequence s_wake_lock;
      state_reg == ST_WAKE ##1 state_reg == ST_RUN;
   endsequence

   stby_entry_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE6
      s_stby_write |=> s_stby_off)
      else $error("standby did not switch off pll, transceiver and core");
   stby_exit_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE7
      state_reg == ST_STANDBY && wake_any && pwr_s |=> state_reg == ST_WAKE)
      else $error("wake source ignored in standby");
   wake_any_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE15
      lp_active && !wake_any && pwr_s |=> state_reg == $past(state_reg))
      else $error("left low power with no wake source");
   stby_restart_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE4
      state_reg == ST_STANDBY ##1 state_reg == ST_WAKE |-> cpu_rst)
      else $error("core not held in reset after standby");
   lock_time_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE4
      s_wake_lock |-> $past(wake_cyc_reg) == PLL_LOCK_LAST)
      else $error("wake lock time wrong");
   susp_pc_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE1
      state_reg == ST_SUSPEND && !hrst_s && pwr_s |=> !cpu_rst)
      else $error("program counter lost in suspend");
   susp_wake_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE1
      state_reg == ST_WAKE && susp_wake_reg |-> !cpu_rst)
      else $error("core reset during wake from suspend");
   susp_clk_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE14
      state_reg == ST_SUSPEND |-> usb3_phy_clk_en && !sys_clk_en && !pll_en && core_pwr_en)
      else $error("suspend clocks wrong");
   off_wipe_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE8
      !pwr_s |=> wake_cfg_reg == WAKE_RST && pull_reg == PULL_RST && drv_reg == DRV_RST)
      else $error("configuration kept through power-down");
   off_state_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE9
      !pwr_s |=> state_reg == ST_OFF ##1 (state_reg == ST_OFF || pwr_s))
      else $error("power-down not entered on supply loss");
   stby_keep_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE2
      state_reg == ST_STANDBY && pwr_s && !hrst_s && !wr_pend_reg |=> $stable(pull_reg) && $stable(gout_reg))
      else $error("configuration lost in standby");
   drv_hold_a: assert property (@(posedge core_clk) disable iff (rst) // see RULE11
      !lp_active && !$past(lp_active) |-> drive_str == $past(drv_reg))
      else $error("drive strength not applied");
endmodule : lpm_ctrl
`default_nettype wire

// *** sim/lpm_env.sv ***
`default_nettype none
// Board-side stand-in: supply, wake pins and the pad wires
module lpm_env
   import lpm_pkg::*;
(
   input wire logic core_clk,
   input wire logic [3:0] want,
   input wire logic [GPIO_N-1:0] o,
   input wire logic [GPIO_N-1:0] oe,
   input wire logic [GPIO_N-1:0] pu,
   input wire logic [GPIO_N-1:0] pd,
   output logic vbus_det,
   output logic level_pin,
   output logic hard_rst_n,
   output logic core_pwr_good,
   output logic [GPIO_N-1:0] gpio_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [GPIO_N-1:0] junk = 12'hA5A;
   // Pins move just after an edge; floating pads toggle so no level is invented
   always @(posedge core_clk) begin
      {core_pwr_good, hard_rst_n, level_pin, vbus_det} <= want;
      junk <= ~junk;
   end
   // Driver wins, then the pull, else the pad floats
   always_comb gpio_i = (oe & o) | (~oe & pu) | (~oe & ~pu & ~pd & junk);
endmodule : lpm_env
`default_nettype wire

// *** sim/testbench.sv ***
`default_nettype none
module testbench
   import lpm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0] want = 4'hE; // Power good, hard reset off, level high, no VBUS
   logic hreadyout, hresp, vbus_det, level_pin, hard_rst_n, core_pwr_good, saw;
   logic pll_en, usb_xcvr_en, usb3_phy_clk_en, sys_clk_en, core_pwr_en, cpu_rst, buf_clear;
   logic [31:0] hrdata;
   logic [GPIO_N-1:0] gpio_i, gpio_o, gpio_oe, gpio_pu, gpio_pd;
   logic [2*IF_N-1:0] drive_str;
   int n_fail = 0;
   int checks_done = 0;
   lpm_ctrl dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .core_pwr_good(core_pwr_good), .hard_rst_n(hard_rst_n),
      .vbus_det(vbus_det), .level_pin(level_pin), .gpio_i(gpio_i), .pll_en(pll_en),
      .usb_xcvr_en(usb_xcvr_en), .usb3_phy_clk_en(usb3_phy_clk_en), .sys_clk_en(sys_clk_en),
      .core_pwr_en(core_pwr_en), .cpu_rst(cpu_rst), .buf_clear(buf_clear), .gpio_o(gpio_o),
      .gpio_oe(gpio_oe), .gpio_pu(gpio_pu), .gpio_pd(gpio_pd), .drive_str(drive_str));
   lpm_env env (.core_clk(core_clk), .want(want), .o(gpio_o), .oe(gpio_oe), .pu(gpio_pu),
      .pd(gpio_pd), .vbus_det(vbus_det), .level_pin(level_pin), .hard_rst_n(hard_rst_n),
      .core_pwr_good(core_pwr_good), .gpio_i(gpio_i));
   // ------------------------------
   // Bus and check helpers
   // ------------------------------
   initial forever #25 core_clk = ~core_clk;
   // Remembers whether the core was held in reset since last cleared
   always @(posedge core_clk) if (cpu_rst !== 1'b0) saw = 1'b1;
   task automatic end_sim;
      $display("Counts: checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Address phase held until hready, then data phase held until hready
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(a, 1'b1, d, v);
   endtask : wr
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      bus(a, 1'b0, 32'h0, v);
      chk(nm, exp, v);
   endtask : rdchk
   task automatic pins(input logic [3:0] p);
      @(posedge core_clk);
      want <= p;
   endtask : pins
   // Polls the state field; bounded so a stuck design ends the wait
   task automatic wait_state(input logic [2:0] s);
      logic [31:0] v;
      v = 32'hFFFFFFFF;
      for (int i = 0; i < 100 && v[2:0] !== s; i++) bus(OFS_STAT, 1'b0, 32'h0, v);
      chk("state", {29'h0, s}, {29'h0, v[2:0]});
   endtask : wait_state
   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic t_cfg;
      wr(OFS_PULL, 32'h555559);
      wr(OFS_GOE, 32'h0F0);
      wr(OFS_GOUT, 32'h0A0);
      wr(OFS_DRV, 32'hE4);
      repeat (4) @(posedge core_clk);
      chk("pull_up", 32'hFFD, {20'h0, gpio_pu});
      chk("pull_dn", 32'h002, {20'h0, gpio_pd});
      chk("drive", 32'hE4, {24'h0, drive_str});
      chk("hresp", 32'h0, {31'h0, hresp});
      rdchk("gin", OFS_GIN, 32'hFAD);
      rdchk("unmapped", 8'h40, 32'h0);
   endtask : t_cfg
   task automatic t_standby;
      rdchk("gin_pre", OFS_GIN, 32'hFAD);
      wr(OFS_CTRL, 32'h1);
      @(posedge core_clk);
      chk("buf_clear", 32'h1, {31'h0, buf_clear});
      @(posedge core_clk);
      chk("stby_pwr", 32'h2, {26'h0, pll_en, usb_xcvr_en, core_pwr_en, sys_clk_en, cpu_rst, buf_clear});
      wr(OFS_GOUT, 32'h00F);
      chk("pads_hold", 32'h0A0, {20'h0, gpio_o});
      saw = 1'b0;
      pins(4'hF);
      wait_state(ST_RUN);
      chk("pc_reset", 32'h1, {31'h0, saw});
      chk("cfg_kept", 32'h00F, {20'h0, gpio_o});
      rdchk("vbus_cause", OFS_STAT, 32'h10);
      wr(OFS_STAT, 32'hF0);
   endtask : t_standby
   task automatic t_suspend;
      pins(4'hD);
      wr(OFS_WAKE, 32'h6);
      wr(OFS_CTRL, 32'h2);
      repeat (2) @(posedge core_clk);
      chk("susp_clk", 32'h2, {30'h0, usb3_phy_clk_en, sys_clk_en});
      saw = 1'b0;
      pins(4'hF);
      wait_state(ST_RUN);
      chk("pc_kept", 32'h0, {31'h0, saw});
      rdchk("lvl_cause", OFS_STAT, 32'h20);
   endtask : t_suspend
   task automatic t_hrst_off;
      logic [31:0] v;
      wr(OFS_STAT, 32'hF0);
      wr(OFS_WAKE, 32'h0);
      wr(OFS_CTRL, 32'h1);
      pins(4'hB);
      pins(4'hF);
      wait_state(ST_RUN);
      bus(OFS_STAT, 1'b0, 32'h0, v);
      chk("hrst_cause", 32'h40, v & 32'h40);
      wr(OFS_GOUT, 32'h5);
      pins(4'h7);
      repeat (6) @(posedge core_clk);
      chk("off_pwr", 32'h0, {31'h0, core_pwr_en});
      pins(4'hF);
      wait_state(ST_RUN);
      bus(OFS_STAT, 1'b0, 32'h0, v);
      chk("reload", 32'h80, v & 32'h80);
      rdchk("gout_lost", OFS_GOUT, 32'h0);
   endtask : t_hrst_off
   // Main sequence, then a watchdog well past the expected run length
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      wait_state(ST_RUN);
      rdchk("wake_rst", OFS_WAKE, {29'h0, WAKE_RST});
      rdchk("por_reload", OFS_STAT, 32'h80);
      wr(OFS_STAT, 32'hF0);
      t_cfg();
      t_standby();
      t_suspend();
      t_hrst_off();
      end_sim();
   end
   initial begin
      #2000000;
      n_fail++;
      end_sim();
   end
endmodule : testbench
`default_nettype wire
